// ==== verif/requestor_model.sv ====
// Far-side requestor set: presents requests and waits passively for grant
`default_nettype none
module requestor_model
	import storage_port_pkg::*;
#(
	parameter int NREQ = 9,
	parameter int AW = 5
) (
	// Clock
	input wire logic clock,
	// Answers
	input wire logic [NREQ-1:0] grant,
	input wire logic [NREQ-1:0] ack,
	input wire logic err_irq,
	// Requests
	output logic [NREQ-1:0] req,
	output logic [NREQ-1:0] req_wr,
	output logic [2*NREQ-1:0] req_half,
	output logic [NREQ*AW-1:0] req_addr,
	output logic [NREQ-1:0] req_apar,
	output logic [NREQ*DW-1:0] req_wdata,
	output logic [2*NREQ-1:0] req_wpar
);
	timeunit 1ns;
	timeprecision 1ps;
	int cyc;
	initial begin
		cyc = 0;
		req = '0;
		req_wr = '0;
		req_half = '0;
		req_addr = '0;
		req_apar = '0;
		req_wdata = '0;
		req_wpar = '0;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
	end
	task automatic issue(input int r, input logic wr, input logic [1:0] half,
		input logic [AW-1:0] a, input logic [DW-1:0] d, input bit bap, input bit bwp,
		output int gcyc, output int ack_k, output int irq_k);
		gcyc = -1;
		ack_k = 0;
		irq_k = 0;
		@(posedge clock);
		req[r] <= 1'h1;
		req_wr[r] <= wr;
		req_half[2*r +: 2] <= half;
		req_addr[r*AW +: AW] <= a;
		req_apar[r] <= ~^a ^ bap;
		req_wdata[r*DW +: DW] <= d;
		req_wpar[2*r +: 2] <= {~^d[DW-1:HW], ~^d[HW-1:0] ^ bwp};
		// Held unchanged while a busy module keeps us waiting
		for (int n = 0; n < 400 && gcyc < 0; n++) begin
			@(negedge clock);
			if (grant[r] === 1'h1) begin
				gcyc = cyc;
			end
		end
		@(posedge clock);
		// Released address and data lines show the inverse, never the stale value
		req[r] <= 1'h0;
		req_addr[r*AW +: AW] <= ~a;
		req_wdata[r*DW +: DW] <= ~d;
		for (int n = 1; n <= 90 && gcyc >= 0; n++) begin
			@(negedge clock);
			if (ack[r] === 1'h1 && ack_k == 0) begin
				ack_k = n;
			end
			if (err_irq === 1'h1 && irq_k == 0) begin
				irq_k = n;
			end
		end
	endtask : issue
endmodule : requestor_model
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the secondary storage port
`default_nettype none
module tb
	import storage_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Setup
	// ****************************************
	localparam int NR = SET_PORTS;
	localparam int AWT = 5;
	localparam int ACK_AT = CYCLE_CYC + 1;
	logic clock;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic ilv2 = 1'h0;
	logic [1:0] mod_online = 2'h3;
	logic [NR-1:0] req, req_wr, grant, ack, req_apar;
	logic [2*NR-1:0] req_half, req_wpar, rpar;
	logic [NR*AWT-1:0] req_addr;
	logic [NR*DW-1:0] req_wdata, rdata;
	logic err_irq;
	logic [7:0] err_status;
	int n_fail;
	int cmp_count;
	integer seed;
	logic [DW-1:0] mem [int];
	logic [AWT-1:0] a;
	logic [DW-1:0] d;
	extended_storage_ecc_port #(.NUM_MODULES(2), .MODULE_WORDS(16), .EXPANDED(1'h0)) dut_u (
		.CLOCK(clock),
		.RST(rst),
		.CE(ce),
		.ILV2(ilv2),
		.MOD_ONLINE(mod_online),
		.REQ(req),
		.REQ_WR(req_wr),
		.REQ_HALF(req_half),
		.REQ_ADDR(req_addr),
		.REQ_APAR(req_apar),
		.REQ_WDATA(req_wdata),
		.REQ_WPAR(req_wpar),
		.GRANT(grant),
		.ACK(ack),
		.RDATA(rdata),
		.RPAR(rpar),
		.ERR_IRQ(err_irq),
		.ERR_STATUS(err_status)
	);
	requestor_model #(.NREQ(NR), .AW(AWT)) pm (.clock(clock), .grant(grant), .ack(ack),
		.err_irq(err_irq), .req(req), .req_wr(req_wr), .req_half(req_half), .req_addr(req_addr),
		.req_apar(req_apar), .req_wdata(req_wdata), .req_wpar(req_wpar));
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic compare(input logic [63:0] got, input logic [63:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, m, got, exp);
		end
	endtask : compare
	// Model merges halves into the stored word and predicts the answer
	task automatic op(input int r, input logic wr, input logic [1:0] h, input logic [AWT-1:0] ad,
		input logic [DW-1:0] dt);
		int g, ak, ik;
		logic [DW-1:0] e;
		pm.issue(r, wr, h, ad, dt, 1'b0, 1'b0, g, ak, ik);
		e = mem.exists(ad) ? mem[ad] : dt;
		if (wr) begin
			if (h[1]) e[DW-1:HW] = dt[DW-1:HW];
			if (h[0]) e[HW-1:0] = dt[HW-1:0];
			mem[ad] = e;
		end
		compare(ak, ACK_AT, "ack delay");
		compare(ik, 0, "spurious irq");
		compare(rdata[r*DW +: DW], e, "word");
		compare(rpar[2*r +: 2], {~^e[DW-1:HW], ~^e[HW-1:0]}, "read parity");
	endtask : op
	task automatic bad(input int r, input logic [AWT-1:0] ad, input bit bap, input bit bwp,
		input logic [1:0] ty, input logic md);
		int g, ak, ik;
		pm.issue(r, 1'b1, HALF_FULL, ad, DW'($random(seed)), bap, bwp, g, ak, ik);
		compare(ik, 1, "irq slot");
		compare(ak, 0, "refused ack");
		compare(err_status, {UNIT_IFACE, ty, md, 4'(r)}, "status");
	endtask : bad
	// Two requestors at once; gap is the grant spacing of the loser
	task automatic race(input int hi, input int lo, input logic il, input logic [AWT-1:0] ad,
		input int gap);
		int gh, gl, k1, k2, k3, k4;
		@(posedge clock);
		ilv2 <= il;
		fork
			pm.issue(lo, 1'b1, HALF_FULL, ad, '0, 1'b0, 1'b0, gl, k1, k2);
			pm.issue(hi, 1'b1, HALF_FULL, ad ^ 5'h01, '1, 1'b0, 1'b0, gh, k3, k4);
		join
		compare(gl - gh, gap, "grant spacing");
	endtask : race
	task automatic complete_run();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		int g0, k0, i0;
		seed = 32'h2A764AD8;
		n_fail = 0;
		cmp_count = 0;
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		for (int il = 0; il < 2; il++) begin
			@(posedge clock);
			ilv2 <= il[0];
			for (int i = 0; i < 4; i++) begin
				a = AWT'($random(seed));
				d = DW'({$random(seed), $random(seed)});
				op((i * 3 + il) % NR, 1'b1, HALF_FULL, a, d);
				op((i * 3 + il + 4) % NR, 1'b0, 2'h0, a, '0);
				op(i % NR, 1'b1, 2'(i % 2 + 1), a, ~d);
				op(8, 1'b0, 2'h0, a, '0);
			end
		end
		race(0, 4, 1'b0, 5'h03, ACK_AT);
		race(3, 8, 1'b0, 5'h12, ACK_AT);
		race(6, 7, 1'b0, 5'h08, ACK_AT);
		// One grant per cycle: a second module is reached on the next cycle
		race(0, 1, 1'b1, 5'h08, 1);
		@(posedge clock);
		ilv2 <= 1'h0;
		bad(2, 5'h13, 1'b1, 1'b0, ERR_ADDR, 1'h1);
		bad(5, 5'h04, 1'b0, 1'b1, ERR_DATA, 1'h0);
		@(posedge clock);
		mod_online <= 2'h2;
		bad(4, 5'h02, 1'b0, 1'b0, ERR_PART, 1'h0);
		op(8, 1'b1, HALF_FULL, 5'h06, 36'h9A5C3E71B);
		op(8, 1'b0, 2'h0, 5'h06, '0);
		op(1, 1'b1, HALF_FULL, 5'h16, 36'h1F00DCAFE);
		// Enable low for five edges in mid-cycle stretches the answer by five
		fork
			pm.issue(2, 1'b1, HALF_FULL, 5'h16, 36'h0ACE5B00F, 1'b0, 1'b0, g0, k0, i0);
			begin
				repeat (3) @(posedge clock);
				ce <= 1'h0;
				repeat (5) @(posedge clock);
				ce <= 1'h1;
			end
		join
		compare(k0, ACK_AT + 5, "frozen ack");
		compare(i0, 0, "frozen irq");
		compare(rdata[2*DW +: DW], 36'h0ACE5B00F, "frozen word");
		complete_run();
	end
endmodule : tb
`default_nettype wire

// ==== verilog/extended_storage_ecc_port.sv ====
// Secondary storage port: priority access, module slots, parity and correcting code
`default_nettype none
module extended_storage_ecc_port
	import storage_port_pkg::*;
#(
	parameter int NUM_MODULES = MAX_MODULES,
	parameter int MODULE_WORDS = MODULE_WORDS_DOC,
	parameter bit EXPANDED = 1'h0,
	localparam int NREQ = SET_PORTS * (EXPANDED ? 2 : 1),
	localparam int MB = $clog2(NUM_MODULES),
	localparam int OB = $clog2(MODULE_WORDS),
	localparam int AW = MB + OB,
	localparam int RB = $clog2(NREQ),
	localparam int ST_W = 3 + MB + RB
) (
	// Clock, reset and enable
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	// Configuration
	input wire logic ILV2,
	input wire logic [NUM_MODULES-1:0] MOD_ONLINE,
	// Requests
	input wire logic [NREQ-1:0] REQ,
	input wire logic [NREQ-1:0] REQ_WR,
	input wire logic [2*NREQ-1:0] REQ_HALF,
	input wire logic [NREQ*AW-1:0] REQ_ADDR,
	input wire logic [NREQ-1:0] REQ_APAR,
	input wire logic [NREQ*DW-1:0] REQ_WDATA,
	input wire logic [2*NREQ-1:0] REQ_WPAR,
	// Answers
	output logic [NREQ-1:0] GRANT,
	output logic [NREQ-1:0] ACK,
	output logic [NREQ*DW-1:0] RDATA,
	output logic [2*NREQ-1:0] RPAR,
	// Error report
	output logic ERR_IRQ,
	output logic [ST_W-1:0] ERR_STATUS
);
	localparam int CNT_W = $clog2(CYCLE_CYC);
	localparam int ST_TYP = RB + MB;
	localparam int CYC_I = CYCLE_CYC;

	default clocking cb @(posedge CLOCK iff CE);
	endclocking
	default disable iff (RST);

	// ****************************************
	// Size checks
	// ****************************************
	if (NUM_MODULES < 2 || (NUM_MODULES & (NUM_MODULES - 1)) != 0 ||
		(MODULE_WORDS & (MODULE_WORDS - 1)) != 0 ||
		NUM_MODULES * MODULE_WORDS > MAX_WORDS) begin : g_bad_size
		$error("unsupported storage size");
	end

	logic [MB-1:0] mod_r [NREQ];
	logic [OB-1:0] off_r [NREQ];
	logic [NREQ-1:0] apar_bad;
	logic [NREQ-1:0] wpar_bad;
	logic [NREQ-1:0] offline;
	logic [NREQ-1:0] elig;
	logic [NREQ-1:0] gnt;
	logic [NUM_MODULES-1:0] busy;
	logic [NUM_MODULES-1:0] done_m;
	logic [NUM_MODULES-1:0] merr_m;
	logic [RB-1:0] own_m [NUM_MODULES];
	logic [PW-1:0] rd_m [NUM_MODULES];
	err_type_t mtyp_m [NUM_MODULES];
	logic [RB-1:0] win;
	logic refused;
	logic start;
	logic [NREQ-1:0] ack_d;
	logic err_d;
	logic [ST_W-1:0] stat_d;
	logic [NREQ-1:0] ack_q;
	logic irq_q;
	logic [ST_W-1:0] stat_q;
	logic [NREQ*DW-1:0] rd_q;
	logic [2*NREQ-1:0] rp_q;
	err_type_t typ_if;

	// ****************************************
	// Request decode
	// ****************************************
	// Second set, when fitted, repeats the first at lower priority
	for (genvar r = 0; r < NREQ; r++) begin : g_req
		wire logic [AW-1:0] a = REQ_ADDR[r*AW +: AW];
		wire logic [DW-1:0] w = REQ_WDATA[r*DW +: DW];
		wire logic [MB-1:0] mod_lin = a[AW-1:OB];
		wire logic [MB-1:0] mod_il = MB'({a[AW-1:OB] >> 1, a[0]});
		assign mod_r[r] = ILV2 ? mod_il : mod_lin;
		assign off_r[r] = ILV2 ? a[OB:1] : a[OB-1:0];
		assign apar_bad[r] = ~^{a, REQ_APAR[r]};
		assign wpar_bad[r] = REQ_WR[r] & (~^{w[DW-1:HW], REQ_WPAR[2*r+1]} |
			~^{w[HW-1:0], REQ_WPAR[2*r]});
		assign offline[r] = ~MOD_ONLINE[mod_r[r]] &
			~((r % SET_PORTS == MAINT_IDX) && (mod_r[r] == '0));
		assign elig[r] = CE & REQ[r] & ~busy[mod_r[r]];

		chk_wait_busy: assert property (busy[mod_r[r]] |-> !gnt[r])
			else $error("grant to a busy module");
	end

	// ****************************************
	// Fixed priority arbiter
	// ****************************************
	// Lowest index wins: each set's I/O ports sit at indices below that set's processors
	assign gnt = elig & (~elig + NREQ'(1));
	assign GRANT = gnt;

	always_comb begin
		win = '0;
		for (int i = NREQ - 1; i >= 0; i--) begin
			if (gnt[i]) begin
				win = RB'(i);
			end
		end
	end

	assign refused = (|gnt) & (apar_bad[win] | wpar_bad[win] | offline[win]);
	assign start = (|gnt) & ~refused;
	assign typ_if = apar_bad[win] ? ERR_ADDR : offline[win] ? ERR_PART : ERR_DATA;

	chk_grant_onehot: assert property ($onehot0(gnt))
		else $error("more than one grant");
	chk_io_first: assert property (|elig[IOP_PORTS-1:0] |-> |gnt[IOP_PORTS-1:0])
		else $error("processor granted over waiting I/O port");
	chk_addr_par: assert property ((|gnt) && apar_bad[win] |-> !start ##1
		(ERR_IRQ && ERR_STATUS[ST_TYP +: 2] == ERR_ADDR))
		else $error("bad address parity not refused");

	// ****************************************
	// Storage module slots
	// ****************************************
	for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
		slot_state_t st_q;
		logic [CNT_W-1:0] cnt_q;
		logic [RB-1:0] own_q;
		logic [AW-1:0] addr_q;
		logic [OB-1:0] off_q;
		logic ap_q;
		logic wr_q;
		logic [1:0] half_q;
		logic [1:0] wp_q;
		logic [DW-1:0] wd_q;
		logic [WW-1:0] mem [MODULE_WORDS];
		wire logic go = start & (mod_r[win] == MB'(m));
		wire logic [WW-1:0] word = mem[off_q];
		wire logic [PW-1:0] raw = word[PW-1:0];
		wire logic [CW-1:0] syn = ecc_syn(raw, word[WW-1:PW]);
		wire logic [PW-1:0] fixed = ecc_fix(raw, syn);
		wire logic multi = ecc_multi(syn);
		wire logic part = half_q != HALF_FULL;
		wire logic [PW-1:0] merged = {half_q[1] ? wp_q[1] : fixed[PW-1],
			half_q[0] ? wp_q[0] : fixed[PW-2],
			half_q[1] ? wd_q[DW-1:HW] : fixed[DW-1:HW],
			half_q[0] ? wd_q[HW-1:0] : fixed[HW-1:0]};
		wire logic last = (st_q == SLOT_BUSY) && (cnt_q == '0);
		wire logic ma_bad = ~^{addr_q, ap_q};
		wire logic [1:0] chp = wr_q ? wp_q : fixed[PW-1:DW];
		wire logic [DW-1:0] chd = wr_q ? wd_q : fixed[DW-1:0];
		wire logic md_bad = ~^{chd[DW-1:HW], chp[1]} | ~^{chd[HW-1:0], chp[0]};
		wire logic mb_bad = multi & (~wr_q | part);
		wire logic do_wr = last & wr_q & ~ma_bad & ~md_bad & ~mb_bad;

		assign busy[m] = st_q == SLOT_BUSY;
		assign done_m[m] = last;
		assign own_m[m] = own_q;
		// A write answers with the merged word, also when an error stops it being stored
		assign rd_m[m] = wr_q ? merged : fixed;
		assign merr_m[m] = last & (ma_bad | md_bad | mb_bad);
		assign mtyp_m[m] = ma_bad ? ERR_ADDR : mb_bad ? ERR_MULTI : ERR_DATA;

		always_ff @(posedge CLOCK) begin
			if (RST) begin
				st_q <= SLOT_IDLE;
				cnt_q <= '0;
			end else if (CE) begin
				case (st_q)
					SLOT_IDLE: begin
						if (go) begin
							st_q <= SLOT_BUSY;
							cnt_q <= CNT_W'(CYCLE_CYC - 1);
						end
					end
					SLOT_BUSY: begin
						if (last) begin
							st_q <= SLOT_IDLE;
						end else begin
							cnt_q <= cnt_q - CNT_W'(1);
						end
					end
					default: st_q <= SLOT_IDLE;
				endcase
			end
		end

		// Request fields are copied so the module checks its own view
		always_ff @(posedge CLOCK) begin
			if (CE && go) begin
				own_q <= win;
				addr_q <= REQ_ADDR[win*AW +: AW];
				off_q <= off_r[win];
				ap_q <= REQ_APAR[win];
				wr_q <= REQ_WR[win];
				half_q <= REQ_HALF[2*win +: 2];
				wp_q <= REQ_WPAR[2*win +: 2];
				wd_q <= REQ_WDATA[win*DW +: DW];
			end
		end

		// Storage is not cleared: a word never written may report errors
		always_ff @(posedge CLOCK) begin
			if (CE && do_wr) begin
				mem[off_q] <= {ecc_gen(merged), merged};
			end
		end

		sequence s_cycle;
			go ##[CYC_I:CYC_I] last;
		endsequence
		chk_cycle_len: assert property (go |=> !last [*8])
			else $error("module cycle ended early");
		chk_ack_time: assert property (s_cycle |=> ACK[own_q])
			else $error("answer not given after module cycle");
		chk_store_code: assert property (do_wr |=>
			mem[$past(off_q)][WW-1:PW] == ecc_gen(mem[$past(off_q)][PW-1:0]))
			else $error("stored code does not match word");
		chk_multi_irq: assert property (last && mb_bad |=> ERR_IRQ)
			else $error("multi-bit error without interrupt");
	end

	// ****************************************
	// Answers and error status
	// ****************************************
	always_comb begin
		ack_d = '0;
		for (int i = 0; i < NUM_MODULES; i++) begin
			if (done_m[i]) begin
				ack_d[own_m[i]] = 1'h1;
			end
		end
	end

	// Interface errors outrank module errors; lowest module wins a tie
	always_comb begin
		err_d = 1'h0;
		stat_d = '0;
		for (int i = NUM_MODULES - 1; i >= 0; i--) begin
			if (merr_m[i]) begin
				err_d = 1'h1;
				stat_d = {UNIT_MOD, mtyp_m[i], MB'(i), own_m[i]};
			end
		end
		if (refused) begin
			err_d = 1'h1;
			stat_d = {UNIT_IFACE, typ_if, mod_r[win], win};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack_q <= '0;
			irq_q <= 1'h0;
			stat_q <= '0;
			rd_q <= '0;
			rp_q <= '0;
		end else if (CE) begin
			ack_q <= ack_d;
			irq_q <= err_d;
			if (err_d) begin
				stat_q <= stat_d;
			end
			for (int i = 0; i < NUM_MODULES; i++) begin
				if (done_m[i]) begin
					rd_q[own_m[i]*DW +: DW] <= rd_m[i][DW-1:0];
					rp_q[own_m[i]*2 +: 2] <= rd_m[i][PW-1:DW];
				end
			end
		end
	end

	assign ACK = ack_q;
	assign RDATA = rd_q;
	assign RPAR = rp_q;
	assign ERR_IRQ = irq_q;
	assign ERR_STATUS = stat_q;

	chk_irq_cause: assert property (ERR_IRQ |-> $past(refused) || $past(|merr_m))
		else $error("interrupt without a detected error");

endmodule : extended_storage_ecc_port
`default_nettype wire

// ==== verilog/storage_port_pkg.sv ====
// Constants, types and correcting-code functions for the secondary storage port
`default_nettype none
package storage_port_pkg;
	// ****************************************
	// Geometry
	// ****************************************
	localparam int MODULE_WORDS_DOC = 131072;
	localparam int MAX_WORDS = 1048576;
	localparam int MAX_MODULES = MAX_WORDS / MODULE_WORDS_DOC;
	localparam int IOP_PORTS = 4;
	localparam int CAU_PORTS = 4;
	localparam int MAINT_PORTS = 1;
	localparam int SET_PORTS = IOP_PORTS + CAU_PORTS + MAINT_PORTS;
	localparam int MAINT_IDX = IOP_PORTS + CAU_PORTS;
	// ****************************************
	// Word layout
	// ****************************************
	localparam int DW = 36;
	localparam int HW = 18;
	localparam int PW = DW + 2;
	localparam int CW = 7;
	localparam int HB = CW - 1;
	localparam int WW = PW + CW;
	localparam int NPOS = WW - 1;
	localparam logic [1:0] HALF_FULL = 2'h3;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CYCLE_NS = 800;
	localparam int CLK_NS = 10;
	localparam int CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
	// ****************************************
	// Status and states
	// ****************************************
	typedef enum logic [1:0] {
		ERR_ADDR = 2'h0,
		ERR_DATA = 2'h1,
		ERR_MULTI = 2'h2,
		ERR_PART = 2'h3
	} err_type_t;
	localparam logic UNIT_IFACE = 1'h0;
	localparam logic UNIT_MOD = 1'h1;
	typedef enum logic {
		SLOT_IDLE = 1'h0,
		SLOT_BUSY = 1'h1
	} slot_state_t;
	// ****************************************
	// Correcting code
	// ****************************************
	function automatic logic [NPOS:1] spread(input logic [PW-1:0] p);
		int k;
		logic [NPOS:1] c;
		k = 0;
		c = '0;
		for (int i = 1; i <= NPOS; i++) begin
			if ((i & (i - 1)) != 0) begin
				c[i] = p[k];
				k++;
			end
		end
		return c;
	endfunction : spread
	function automatic logic [PW-1:0] gather(input logic [NPOS:1] c);
		int k;
		logic [PW-1:0] p;
		k = 0;
		p = '0;
		for (int i = 1; i <= NPOS; i++) begin
			if ((i & (i - 1)) != 0) begin
				p[k] = c[i];
				k++;
			end
		end
		return p;
	endfunction : gather
	function automatic logic [HB-1:0] hsum(input logic [NPOS:1] c);
		logic [HB-1:0] s;
		s = '0;
		for (int i = 1; i <= NPOS; i++) begin
			if (c[i]) begin
				s = s ^ HB'(i);
			end
		end
		return s;
	endfunction : hsum
	function automatic logic [CW-1:0] ecc_gen(input logic [PW-1:0] p);
		logic [HB-1:0] h;
		h = hsum(spread(p));
		return {^{p, h}, h};
	endfunction : ecc_gen
	function automatic logic [CW-1:0] ecc_syn(input logic [PW-1:0] p, input logic [CW-1:0] e);
		return {^{p, e}, hsum(spread(p)) ^ e[HB-1:0]};
	endfunction : ecc_syn
	function automatic logic [PW-1:0] ecc_fix(input logic [PW-1:0] p, input logic [CW-1:0] s);
		logic [NPOS:1] c;
		c = spread(p);
		if (s[CW-1] && s[HB-1:0] != '0 && s[HB-1:0] <= HB'(NPOS)) begin
			c[s[HB-1:0]] = ~c[s[HB-1:0]];
		end
		return gather(c);
	endfunction : ecc_fix
	function automatic logic ecc_multi(input logic [CW-1:0] s);
		return (!s[CW-1] && s[HB-1:0] != '0) || (s[CW-1] && s[HB-1:0] > HB'(NPOS));
	endfunction : ecc_multi
endpackage : storage_port_pkg
`default_nettype wire
